// ===== hdl/nsp_pkg.sv
// Package for the per-sector ECC parity and error-location register bank
package nsp_pkg;
    localparam int SECTORS = 8;
    localparam int SECTOR_BYTES = 512;
    localparam int ADDR_W = 8;
    // Register byte offsets, one aligned word per sector
    localparam logic [7:0] PR_BASE = 8'h00;
    localparam logic [7:0] PR_LAST = 8'h1C;
    // Field layout
    localparam int BIT_LSB = 0;
    localparam int BIT_W = 3;
    localparam int WORD_LSB = 3;
    localparam int WORD_W = 9;
    localparam int PAR_LSB = 12;
    localparam int PAR_W = 12;
    localparam logic [31:0] PR_RESET = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage : nsp_pkg

// ===== hdl/nsp_sector_ecc.sv
// Per-sector Hamming ECC over 512-byte segments with read-only parity registers
// Overview of operation
// - Register 0 holds code and error location for page bytes 0 to 511.
// - Register 1 covers bytes 512 to 1023 and each next register the next 512 bytes.
// - Register 5 covers bytes 2560 to 3071, one register per segment up to 4096 bytes.
// - On a single error the bit field gives the flipped bit within the faulty byte.
// - On a single error the word field gives the faulty byte index within the segment.
// - On multiple errors the location fields are meaningless and must not be used.
module nsp_sector_ecc #(
    parameter int SECTORS = nsp_pkg::SECTORS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Page data stream
    input wire logic page_start,
    input wire logic data_valid,
    input wire logic [7:0] data_byte,
    // Stored code for read-back check, one word per sector
    input wire logic read_mode,
    input wire logic code_valid,
    input wire logic [23:0] stored_code,
    // Register port
    input wire logic [nsp_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Status
    output logic [SECTORS-1:0] code_bytes_error_flag,
    output logic [SECTORS-1:0] multi_error_flag,
    output logic [SECTORS-1:0] single_error_flag
);
    localparam int SW = $clog2(SECTORS);

    // Column parity of one byte: odd-position and even-position pair for bits 4/2/1
    function automatic logic [5:0] col_par(input logic [7:0] b);
        col_par[0] = b[0] ^ b[2] ^ b[4] ^ b[6];
        col_par[1] = b[1] ^ b[3] ^ b[5] ^ b[7];
        col_par[2] = b[0] ^ b[1] ^ b[4] ^ b[5];
        col_par[3] = b[2] ^ b[3] ^ b[6] ^ b[7];
        col_par[4] = b[0] ^ b[1] ^ b[2] ^ b[3];
        col_par[5] = b[4] ^ b[5] ^ b[6] ^ b[7];
    endfunction : col_par

    // Code word: bit offset parity [2:0], byte index [11:3], complement [23:12]
    logic [11:0] odd_q, odd_d;
    logic [11:0] even_q, even_d;
    logic [8:0] byte_q, byte_d;
    logic [SW-1:0] sec_q, sec_d;
    logic [23:0] code_q [SECTORS];
    logic [31:0] pr_q [SECTORS];
    logic [31:0] pr_d [SECTORS];
    logic [SECTORS-1:0] ce_q, ce_d, me_q, me_d, se_q, se_d;
    logic [SW-1:0] chk_idx_q, chk_idx_d;
    logic [31:0] rdata_d;
    logic seg_done;
    logic [23:0] seg_code;
    logic [23:0] syn;
    logic [11:0] syn_lo, syn_hi;
    int ones;
    logic [SW+8:0] page_cnt_q, page_cnt_d;

    // Accumulate one segment, byte index within segment
    always_comb begin
        logic [5:0] cp;
        logic par;
        cp = col_par(data_byte);
        par = ^data_byte;
        odd_d = odd_q;
        even_d = even_q;
        byte_d = byte_q;
        sec_d = sec_q;
        seg_done = 1'b0;
        if (page_start) begin
            odd_d = '0;
            even_d = '0;
            byte_d = '0;
            sec_d = '0;
        end else if (data_valid) begin
            odd_d[2:0] = odd_q[2:0] ^ {cp[5], cp[3], cp[1]};
            even_d[2:0] = even_q[2:0] ^ {cp[4], cp[2], cp[0]};
            for (int i = 0; i < 9; i++) begin
                if (byte_q[i]) odd_d[3+i] = odd_q[3+i] ^ par;
                else even_d[3+i] = even_q[3+i] ^ par;
            end
            byte_d = byte_q + 9'h001;
            if (byte_q == 9'h1FF) begin
                seg_done = 1'b1;
                odd_d = '0;
                even_d = '0;
                sec_d = SW'(sec_q + 1'b1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            odd_q <= '0;
            even_q <= '0;
            byte_q <= '0;
            sec_q <= '0;
        end else begin
            odd_q <= odd_d;
            even_q <= even_d;
            byte_q <= byte_d;
            sec_q <= sec_d;
        end
    end

    // Final code includes the last byte of the segment
    always_comb begin
        logic [5:0] cp;
        logic par;
        logic [11:0] o, e;
        cp = col_par(data_byte);
        par = ^data_byte;
        o = odd_q;
        e = even_q;
        o[2:0] = o[2:0] ^ {cp[5], cp[3], cp[1]};
        e[2:0] = e[2:0] ^ {cp[4], cp[2], cp[0]};
        o[11:3] = o[11:3] ^ {9{par}};
        seg_code = {~e, o};
    end

    // Syndrome against stored code
    always_comb begin
        syn = stored_code ^ code_q[chk_idx_q];
        syn_lo = syn[11:0];
        syn_hi = syn[23:12];
        ones = $countones(syn);
    end

    always_comb begin
        for (int s = 0; s < SECTORS; s++) pr_d[s] = pr_q[s];
        ce_d = ce_q;
        me_d = me_q;
        se_d = se_q;
        chk_idx_d = chk_idx_q;
        if (page_start) begin
            ce_d = '0;
            me_d = '0;
            se_d = '0;
            chk_idx_d = '0;
        end
        if (seg_done) begin
            pr_d[sec_q] = {8'h00, seg_code};
        end
        if (code_valid && read_mode && !page_start) begin
            chk_idx_d = SW'(chk_idx_q + 1'b1);
            if (syn == 24'h000000) begin
                // No error
            end else if ((syn_lo ^ syn_hi) == 12'hFFF) begin
                se_d[chk_idx_q] = 1'b1;
                pr_d[chk_idx_q] = {8'h00, syn_hi, syn_lo};
            end else if (ones == 1) begin
                // lone bit shown in low 24
                ce_d[chk_idx_q] = 1'b1;
                pr_d[chk_idx_q] = {8'h00, syn};
            end else begin
                me_d[chk_idx_q] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int s = 0; s < SECTORS; s++) pr_q[s] <= nsp_pkg::PR_RESET;
            ce_q <= '0;
            me_q <= '0;
            se_q <= '0;
            chk_idx_q <= '0;
        end else begin
            for (int s = 0; s < SECTORS; s++) pr_q[s] <= pr_d[s];
            ce_q <= ce_d;
            me_q <= me_d;
            se_q <= se_d;
            chk_idx_q <= chk_idx_d;
        end
    end

    // Code snapshot kept separately so a located error does not corrupt later compares
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int s = 0; s < SECTORS; s++) code_q[s] <= '0;
        end else if (seg_done) begin
            code_q[sec_q] <= seg_code;
        end
    end

    // Read port, writes ignored since the bank is read-only
    always_comb begin
        rdata_d = nsp_pkg::UNMAPPED_READ;
        if (reg_rd && reg_addr[1:0] == 2'b00 && reg_addr <= nsp_pkg::PR_LAST) begin
            rdata_d = pr_q[reg_addr[SW+1:2]];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= '0;
            code_bytes_error_flag <= '0;
            multi_error_flag <= '0;
            single_error_flag <= '0;
        end else begin
            reg_rdata <= rdata_d;
            code_bytes_error_flag <= ce_d;
            multi_error_flag <= me_d;
            single_error_flag <= se_d;
        end
    end

    // Page byte count, cleared on page_start and advanced on data_valid, kept apart from byte_q so the boundary check is independent
    always_comb begin
        page_cnt_d = page_cnt_q;
        if (page_start) begin
            page_cnt_d = '0;
        end else if (data_valid) begin
            page_cnt_d = (SW+9)'(page_cnt_q + 1'b1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            page_cnt_q <= '0;
        end else begin
            page_cnt_q <= page_cnt_d;
        end
    end

    property p_upper_zero;
        @(posedge clk) disable iff (!rst_n) reg_rdata[31:24] == 8'h00;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits nonzero");

    property p_seg_store;
        @(posedge clk) disable iff (!rst_n)
            seg_done |=> pr_q[$past(sec_q)] == {8'h00, $past(seg_code)};
    endproperty
    a_seg_store: assert property (p_seg_store) else $error("segment code not stored");

    property p_seg_step;
        @(posedge clk) disable iff (!rst_n)
            seg_done && !page_start |=> sec_q == SW'($past(sec_q) + 1'b1);
    endproperty
    a_seg_step: assert property (p_seg_step) else $error("segment index not advanced");

    property p_seg_len;
        @(posedge clk) disable iff (!rst_n)
            (data_valid && !page_start && page_cnt_q[8:0] == 9'h1FF) == seg_done
            && (!seg_done || sec_q == page_cnt_q[SW+8:9]);
    endproperty
    a_seg_len: assert property (p_seg_len) else $error("segment not 512 bytes");

    property p_single;
        @(posedge clk) disable iff (!rst_n)
            code_valid && read_mode && !page_start && syn != 24'h0
            && (syn_lo ^ syn_hi) == 12'hFFF
            |=> pr_q[$past(chk_idx_q)][11:0] == $past(syn_lo);
    endproperty
    a_single: assert property (p_single) else $error("single error location wrong");

    property p_single_flag;
        @(posedge clk) disable iff (!rst_n)
            code_valid && read_mode && !page_start && syn != 24'h0
            && (syn_lo ^ syn_hi) == 12'hFFF |=> single_error_flag[$past(chk_idx_q)];
    endproperty
    a_single_flag: assert property (p_single_flag) else $error("single flag missing");

    property p_multi;
        @(posedge clk) disable iff (!rst_n)
            code_valid && read_mode && !page_start && ones > 1
            && (syn_lo ^ syn_hi) != 12'hFFF |=> multi_error_flag[$past(chk_idx_q)];
    endproperty
    a_multi: assert property (p_multi) else $error("multi error flag missing");

    property p_read_lat;
        @(posedge clk) disable iff (!rst_n)
            reg_rd && reg_addr == nsp_pkg::PR_BASE |=> reg_rdata == $past(pr_q[0]);
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("read data wrong");
endmodule : nsp_sector_ecc

// ===== dv/nsp_page_src.sv
// Page byte source standing in for the flash array side
module nsp_page_src (
    // Clock
    input wire logic clk,
    // Page stream
    output logic page_start,
    output logic data_valid,
    output logic [7:0] data_byte
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        page_start = 1'b0;
        data_valid = 1'b0;
        data_byte = 8'h00;
    end
    // whole page, one segment per 512 bytes
    task automatic send_page(input int f[5]);
        logic [7:0] b;
        @(posedge clk) page_start <= 1'b1;
        @(posedge clk) page_start <= 1'b0;
        for (int i = 0; i < nsp_pkg::SECTORS * nsp_pkg::SECTOR_BYTES; i++) begin
            b = i[7:0] ^ i[11:4];
            for (int k = 0; k < 8; k++) begin
                for (int j = 0; j < 5; j++) begin
                    if (i * 8 + k == f[j]) begin
                        b[k] = ~b[k];
                    end
                end
            end
            data_valid <= 1'b1;
            data_byte <= b;
            @(posedge clk);
        end
        data_valid <= 1'b0;
        // Released bus must not keep the last byte
        data_byte <= ~b;
    endtask : send_page
endmodule : nsp_page_src

// ===== dv/tb.sv
// Self-checking bench for the sector parity register bank
module tb;
    timeunit 1ns;
    timeprecision 1ns;
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
    logic clk = 1'b0;
    logic rst_n, read_mode, code_valid, reg_wr, reg_rd;
    logic page_start, data_valid;
    logic [7:0] data_byte, reg_addr;
    logic [23:0] stored_code, c;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [7:0] code_flag, multi_flag, single_flag;
    logic [31:0] w [8];
    logic [31:0] ex [8];
    int n_errors, num_checks;
    initial forever #50 clk = ~clk;
    nsp_page_src i_src (.clk(clk), .page_start(page_start), .data_valid(data_valid),
        .data_byte(data_byte));
    nsp_sector_ecc i_dut (.clk(clk), .rst_n(rst_n), .page_start(page_start),
        .data_valid(data_valid), .data_byte(data_byte), .read_mode(read_mode),
        .code_valid(code_valid), .stored_code(stored_code), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .code_bytes_error_flag(code_flag), .multi_error_flag(multi_flag),
        .single_error_flag(single_flag));
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk) reg_rd <= 1'b0;
        @(negedge clk) q = reg_rdata;
        @(posedge clk);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk) reg_wr <= 1'b0;
    endtask : wr
    task automatic send_code(input logic [23:0] v);
        stored_code <= v;
        code_valid <= 1'b1;
        @(posedge clk) code_valid <= 1'b0;
        @(posedge clk);
    endtask : send_code
    function automatic logic [31:0] loc(input logic [8:0] b, input logic [2:0] k);
        return {8'h00, ~{b, k}, b, k};
    endfunction : loc
    // Reference code of one segment of the page pattern, from the field layout
    function automatic logic [23:0] exp_code(input int s);
        logic [11:0] o, e;
        logic [7:0] b;
        o = 12'h000;
        e = 12'h000;
        for (int i = s * nsp_pkg::SECTOR_BYTES; i < (s + 1) * nsp_pkg::SECTOR_BYTES; i++) begin
            b = i[7:0] ^ i[11:4];
            for (int k = 0; k < 8; k++) begin
                if (b[k]) begin
                    o = o ^ {i[8:0], 3'(k)};
                    e = e ^ ~{i[8:0], 3'(k)};
                end
            end
        end
        return {~e, o};
    endfunction : exp_code
    task automatic end_sim;
        if (n_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    // Three pages of 4096 bytes, well inside this span
    initial begin
        #3_000_000;
        n_errors++;
        end_sim();
    end
    initial begin
        n_errors = 0;
        num_checks = 0;
        {rst_n, read_mode, code_valid, reg_wr, reg_rd} = 5'h00;
        stored_code = 24'h000000;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(8'h00, d);
        `CHK("reset", nsp_pkg::PR_RESET, d)
        i_src.send_page('{-1, -1, -1, -1, -1});
        @(posedge clk);
        for (int s = 0; s < 8; s++) begin
            rd(8'(s * 4), w[s]);
            `CHK("upper", 8'h00, w[s][31:24])
            ex[s] = {8'h00, exp_code(s)};
            `CHK("parity", ex[s], w[s])
        end
        wr(8'h00, 32'hFFFF_FFFF);
        rd(8'h00, d);
        `CHK("ro", ex[0], d)
        rd(8'h20, d);
        `CHK("unmapped", nsp_pkg::UNMAPPED_READ, d)
        rd(8'h02, d);
        `CHK("unaligned", nsp_pkg::UNMAPPED_READ, d)
        // Segment edges, a double flip in sector 2; bit index is byte * 8 + bit
        read_mode <= 1'b1;
        i_src.send_page('{4095, 4096, 22883, 8233, 8270});
        for (int s = 0; s < 8; s++) begin
            c = w[s][23:0];
            if (s == 3) c[10] = ~c[10];
            send_code(c);
        end
        ex[0] = loc(9'd511, 3'd7);
        ex[1] = loc(9'd0, 3'd0);
        ex[5] = loc(9'd300, 3'd3);
        ex[3] = 32'h0000_0400;
        for (int s = 0; s < 8; s++) begin
            rd(8'(s * 4), d);
            if (s != 2) `CHK("loc", ex[s], d)
        end
        `CHK("single", 8'h23, single_flag)
        `CHK("multi", 8'h04, multi_flag)
        `CHK("code", 8'h08, code_flag)
        read_mode <= 1'b0;
        i_src.send_page('{-1, -1, -1, -1, -1});
        `CHK("cleared", 24'h000000, {single_flag, multi_flag, code_flag})
        for (int s = 0; s < 8; s++) begin
            rd(8'(s * 4), d);
            `CHK("again", {8'h00, exp_code(s)}, d)
        end
        end_sim();
    end
endmodule : tb
